// ---- hw/port_cfg.svh ----
/*
  Address map, reset values and field sizes of the byte-wide I/O port.
  Assumes it is included by bare name from the design files.
*/
`ifndef PORT_CFG_SVH
`define PORT_CFG_SVH

// ------------------------------------------------------------------
// register addresses in the internal I/O area
// ------------------------------------------------------------------
`define PORT_ADDR_W          16
`define PORT_LATCH_ADDR      16'hFFD6
`define PORT_DIR_ADDR        16'hFFE6

// ------------------------------------------------------------------
// reset values and read constants
// ------------------------------------------------------------------
`define PORT_LATCH_RST       8'h00
`define PORT_DIR_RST         8'h00
`define PORT_DIR_READ        8'hFF
`define PORT_UNMAPPED_READ   8'h00

// ------------------------------------------------------------------
// pin synchroniser depth
// ------------------------------------------------------------------
`define PORT_SYNC_STAGES     2

`endif

// ---- hw/port_pkg.sv ----
/*
  Types shared by the port block: bus request and pin bundle.
  Assumes port_cfg.svh is on the include path.
*/
`default_nettype none
`include "port_cfg.svh"

package port_pkg;

  // bus request from the cpu side
  typedef struct packed {
    logic                     rd;
    logic                     wr;
    logic                     word;
    logic [`PORT_ADDR_W-1:0]  addr;
    logic [15:0]              wdata;
  } bus_req_t;

  // pin drive bundle: level and enable per pin
  typedef struct packed {
    logic [7:0] level;
    logic [7:0] enable;
  } pin_drive_t;

endpackage : port_pkg

`default_nettype wire

// ---- hw/pin_sync.sv ----
/*
  Two-stage synchroniser for the eight port pin levels.
  Assumes pin levels are asynchronous to CLK_I.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  // a zero-width synchroniser would leave the pin bus undriven
  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync: WIDTH must be at least 1");
  end

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t state_reg;
  sync_state_t state_next;

  // first stage feeds only the second
  always_comb begin
    state_next        = state_reg;
    state_next.meta   = async_i;
    state_next.stable = state_reg.meta;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_o = state_reg.stable;

endmodule // pin_sync

`default_nettype wire

// ---- hw/port_byte.sv ----
/*
  Eight-pin bidirectional port with output latch and write-only
  direction register, reached by cpu byte accesses.
  Assumes a single-cycle read/write strobe on CLK_I and a pad ring that
  resolves each pin from PIN_LEVEL_O / PIN_OE_O.
*/
`timescale 1ns/1ps
`default_nettype none
`include "port_cfg.svh"

module port_byte #(
  parameter int PINS = 8
) (
  input  wire logic                   CLK_I,
  input  wire logic                   RST_I,
  input  wire logic                   BUS_RD_I,
  input  wire logic                   BUS_WR_I,
  input  wire logic                   BUS_WORD_I,
  input  wire logic [`PORT_ADDR_W-1:0] BUS_ADDR_I,
  input  wire logic [15:0]            BUS_WDATA_I,
  output logic      [7:0]             BUS_RDATA_O,
  output logic                        BUS_RVALID_O,
  input  wire logic [PINS-1:0]        PIN_IN_I,
  output logic      [PINS-1:0]        PIN_LEVEL_O,
  output logic      [PINS-1:0]        PIN_OE_O
);

  // ------------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------------
  // the read mux and the pad record are byte wide by construction
  if (PINS != 8) begin : g_bad_pins
    $error("port_byte: PINS must be 8 for a byte port");
  end

  // a shared address would make the decoder pick the latch silently
  if (`PORT_LATCH_ADDR == `PORT_DIR_ADDR) begin : g_bad_map
    $error("port_byte: latch and direction addresses collide");
  end

  if (`PORT_ADDR_W != 16) begin : g_bad_addr_w
    $error("port_byte: the cpu address bus is 16 bits wide");
  end

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  // which register a bus address falls on
  typedef enum logic [1:0] {
    SEL_NONE  = 2'b00,
    SEL_LATCH = 2'b01,
    SEL_DIR   = 2'b10
  } reg_sel_t;

  typedef struct packed {
    logic [7:0]           latch;
    logic [7:0]           dir;
    logic [7:0]           rdata;
    logic                 rvalid;
    port_pkg::pin_drive_t pads;
  } port_state_t;

  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  port_state_t          state_reg;
  port_state_t          state_next;
  port_pkg::bus_req_t   req;
  reg_sel_t             sel;
  logic [7:0]           pin_sync_lvl;
  logic [7:0]           view;
  logic [7:0]           wbyte;
  logic [7:0]           rbyte;

  // ------------------------------------------------------------------
  // input capture
  // ------------------------------------------------------------------
  // strobes come from cpu logic on CLK_I, so they are used as they stand
  assign req = '{
    rd:    BUS_RD_I,
    wr:    BUS_WR_I,
    word:  BUS_WORD_I,
    addr:  BUS_ADDR_I,
    wdata: BUS_WDATA_I
  };

  // pins are asynchronous: two flops before any logic reads them;
  // costs two cycles of latency on pin reads
  pin_sync #(
    .WIDTH (PINS)
  ) u_pin_sync (
    .clk_i   (CLK_I),
    .rst_i   (RST_I),
    .async_i (PIN_IN_I),
    .sync_o  (pin_sync_lvl)
  );

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // one decoder serves both the read and the write path
  function automatic reg_sel_t decode_addr(input logic [`PORT_ADDR_W-1:0] addr);
    if (addr == `PORT_LATCH_ADDR) begin
      decode_addr = SEL_LATCH;
    end else if (addr == `PORT_DIR_ADDR) begin
      decode_addr = SEL_DIR;
    end else begin
      decode_addr = SEL_NONE;
    end
  endfunction

  // word writes keep only the upper byte, lower byte is lost
  function automatic logic [7:0] write_byte(input port_pkg::bus_req_t r);
    write_byte = r.word ? r.wdata[15:8] : r.wdata[7:0];
  endfunction

  // per bit: pin level for inputs, latch for outputs
  function automatic logic [7:0] latch_view(input logic [7:0] latch,
                                            input logic [7:0] dir,
                                            input logic [7:0] pins);
    latch_view = (dir & latch) | (~dir & pins);
  endfunction

  // direction register has no read path, so software cannot see it
  function automatic logic [7:0] read_value(input reg_sel_t   s,
                                            input logic [7:0] v);
    unique case (s)
      SEL_LATCH: read_value = v;
      SEL_DIR:   read_value = `PORT_DIR_READ;
      SEL_NONE:  read_value = `PORT_UNMAPPED_READ;
      default:   read_value = `PORT_UNMAPPED_READ;
    endcase
  endfunction

  // drive level masked by direction, so an input pin never carries
  // a stale latch bit
  function automatic port_pkg::pin_drive_t pad_drive(input logic [7:0] latch,
                                                     input logic [7:0] dir);
    pad_drive.level  = latch & dir;
    pad_drive.enable = dir;
  endfunction

  assign sel   = decode_addr(req.addr);
  assign wbyte = write_byte(req);
  assign view  = latch_view(state_reg.latch, state_reg.dir, pin_sync_lvl);
  assign rbyte = read_value(sel, view);

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    state_next        = state_reg;
    state_next.rvalid = req.rd;
    state_next.rdata  = `PORT_UNMAPPED_READ;
    // a read in the same cycle as a write sees the old register values
    if (req.rd) begin
      state_next.rdata = rbyte;
    end
    if (req.wr) begin
      unique case (sel)
        SEL_LATCH: state_next.latch = wbyte;
        SEL_DIR:   state_next.dir   = wbyte;
        SEL_NONE:  state_next.latch = state_reg.latch;
        default:   state_next.dir   = state_reg.dir;
      endcase
    end
    // pads take the new register values at the same edge
    state_next.pads = pad_drive(state_next.latch, state_next.dir);
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state_reg.latch       <= `PORT_LATCH_RST;
      state_reg.dir         <= `PORT_DIR_RST;
      state_reg.rdata       <= `PORT_UNMAPPED_READ;
      state_reg.rvalid      <= 1'b0;
      state_reg.pads.level  <= 8'h00;
      state_reg.pads.enable <= 8'h00;
    end else begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign BUS_RDATA_O  = state_reg.rdata;
  assign BUS_RVALID_O = state_reg.rvalid;
  assign PIN_LEVEL_O  = state_reg.pads.level;
  assign PIN_OE_O     = state_reg.pads.enable;

endmodule // port_byte

`default_nettype wire

// ---- testbench/port_byte_properties.sv ----
/* Checker for the byte-wide port: bus answers, read values and pin drive.
   Assumes it is bound to port_byte and that port_cfg.svh is on the include path. */
`timescale 1ns/1ps
`default_nettype none
`include "port_cfg.svh"
module port_byte_chk #(
  parameter int PINS = 8
) (
  input wire logic                    CLK_I,
  input wire logic                    RST_I,
  input wire logic                    BUS_RD_I,
  input wire logic                    BUS_WR_I,
  input wire logic                    BUS_WORD_I,
  input wire logic [`PORT_ADDR_W-1:0] BUS_ADDR_I,
  input wire logic [15:0]             BUS_WDATA_I,
  input wire logic [7:0]              BUS_RDATA_O,
  input wire logic                    BUS_RVALID_O,
  input wire logic [PINS-1:0]         PIN_IN_I,
  input wire logic [PINS-1:0]         PIN_LEVEL_O,
  input wire logic [PINS-1:0]         PIN_OE_O
);
  wire da = BUS_ADDR_I == `PORT_DIR_ADDR;
  wire la = BUS_ADDR_I == `PORT_LATCH_ADDR;
  wire dw = BUS_WR_I && da;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  a_rvalid_pulse: assert property (1'b1 |=> BUS_RVALID_O == $past(BUS_RD_I))
    else $error("read valid not one cycle after read");
  a_dir_reads_ones: assert property (BUS_RD_I && da |=> BUS_RDATA_O == 8'hFF)
    else $error("direction read not all ones");
  a_unmapped_zero: assert property (BUS_RD_I && !da && !la |=> BUS_RDATA_O == 8'h00)
    else $error("unmapped read not zero");
  a_dir_byte_write: assert property (dw && !BUS_WORD_I |=> PIN_OE_O == $past(BUS_WDATA_I[7:0]))
    else $error("enable does not follow direction write");
  a_word_upper: assert property (dw && BUS_WORD_I |=> PIN_OE_O == $past(BUS_WDATA_I[15:8]))
    else $error("word write did not store upper byte");
  a_level_gated: assert property ((PIN_LEVEL_O & ~PIN_OE_O) == '0)
    else $error("input pin driven high");
  a_oe_holds: assert property (!dw |=> $stable(PIN_OE_O))
    else $error("enable changed without direction write");
  a_latch_read: assert property (BUS_RD_I && la && &PIN_OE_O |=> BUS_RDATA_O == $past(PIN_LEVEL_O))
    else $error("output pins not read from latch");
  a_reset_clears: assert property ($fell(RST_I) |-> PIN_OE_O == '0 && !BUS_RVALID_O)
    else $error("reset did not make pins inputs");
  c_dir_read: cover property (BUS_RD_I && da);
  c_word_write: cover property (dw && BUS_WORD_I);
  c_rereset: cover property ($fell(RST_I));
endmodule // port_byte_chk
bind port_byte port_byte_chk #(.PINS(PINS)) chk (.*);
`default_nettype wire

// ---- testbench/pin_world.sv ----
/* Far-side circuitry on the eight port pins.
   Assumes one external level per pin wherever the port does not drive. */
`timescale 1ns/1ps
`default_nettype none
module pin_world #(
  parameter int PINS = 8
) (
  input  wire logic [PINS-1:0] oe_i,
  input  wire logic [PINS-1:0] level_i,
  input  wire logic [PINS-1:0] ext_i,
  output logic      [PINS-1:0] pin_o
);
  // driven pins follow the port, the rest keep the outside level
  assign pin_o = (oe_i & level_i) | (~oe_i & ext_i);
endmodule // pin_world
`default_nettype wire

// ---- testbench/port_byte_tb.sv ----
/* Self-checking bench for the byte-wide port.
   Assumes the design files and the pin model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "port_cfg.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin failures++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, a, e); end end
module port_byte_tb;
  localparam logic [15:0] la = `PORT_LATCH_ADDR;
  localparam logic [15:0] da = `PORT_DIR_ADDR;
  logic       clk = 0, rst = 1, rd = 0, wr = 0, word = 0, rvalid;
  logic [15:0] addr = 16'h0000, wdata = 16'h0000;
  logic [7:0] rdata, lvl, oe, pins, ext = 8'h40;
  logic [7:0] got_data;
  logic       got_valid;
  int         failures = 0, tests_run = 0;
  initial forever #5 clk = ~clk;
  port_byte dut (.CLK_I(clk), .RST_I(rst), .BUS_RD_I(rd), .BUS_WR_I(wr), .BUS_WORD_I(word),
    .BUS_ADDR_I(addr), .BUS_WDATA_I(wdata), .BUS_RDATA_O(rdata), .BUS_RVALID_O(rvalid),
    .PIN_IN_I(pins), .PIN_LEVEL_O(lvl), .PIN_OE_O(oe));
  pin_world far (.oe_i(oe), .level_i(lvl), .ext_i(ext), .pin_o(pins));
  // one strobe cycle; the answer is taken before the strobe drops and an
  // idle cycle follows, so no strobe is written twice at one instant
  task automatic acc(input logic r, w, wd, input logic [15:0] a, d);
    rd = r; wr = w; word = wd; addr = a; wdata = d;
    @(negedge clk);
    got_valid = rvalid;
    got_data  = rdata;
    rd = 0; wr = 0;
    @(negedge clk);
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] e);
    acc(1, 0, 0, a, 16'h0000);
    `CHK(got_valid, 1'b1)
    `CHK(got_data, e)
  endtask
  task automatic wr8(input logic [15:0] a, input logic [7:0] d);
    acc(0, 1, 0, a, {8'h00, d});
  endtask
  task automatic print_verdict;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #5000 failures++;
    print_verdict;
  end
  initial begin
    repeat (2) @(negedge clk); rst = 0;
    repeat (2) @(negedge clk);
    rchk(da, 8'hFF);
    rchk(la, 8'h40);
    wr8(da, 8'h3F); `CHK(oe, 8'h3F)
    wr8(la, 8'h80); `CHK(lvl, 8'h00)
    rchk(la, 8'h40);
    wr8(la, 8'h41); `CHK(lvl, 8'h01)
    wr8(da, 8'hFF); `CHK(lvl, 8'h41)
    rchk(la, 8'h41);
    wr8(la, 8'h81); `CHK(lvl, 8'h81)
    rchk(da, 8'hFF);
    wr8(da, 8'hFE); `CHK(lvl, 8'h80)
    acc(0, 1, 1, da, 16'h0F55); `CHK(oe, 8'h0F)
    rchk(16'hFFD7, 8'h00);
    wr8(16'hFFD7, 8'hAA); `CHK(oe, 8'h0F)
    ext = 8'hC3;
    rst = 1; @(negedge clk); rst = 0; `CHK(oe, 8'h00)
    repeat (2) @(negedge clk);
    rchk(la, 8'hC3);
    wr8(da, 8'hFF); `CHK(lvl, 8'h00)
    print_verdict;
  end
endmodule // port_byte_tb
`default_nettype wire
